// >>> core/fei_flash_event_irq.sv
// Purpose: interrupt pin logic of a serial NOR flash with event flags
// Assumes: event sources come from logic on clk_sys; hwReset_n is a pin
// Notes:   reset_n is the power-on reset; hwReset_n acts after synchronising
`timescale 1ns/1ps

module fei_flash_event_irq
    import fei_pkg::*;
(
    // clock and power-on reset
    input  wire logic              clk_sys,
    input  wire logic              reset_n,
    // hardware reset pin, asynchronous to clk_sys
    input  wire logic              hwReset_n,
    // internal event sources
    input  wire logic              busy,
    input  wire logic              ecc2Err,
    input  wire logic              ecc1Err,
    // apb slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [DATA_W-1:0] pwdata,
    output logic      [DATA_W-1:0] prdata,
    output logic                   pready,
    output logic                   pslverr,
    // open-drain interrupt pin
    output logic                   intPinOut,
    output logic                   intPinOe,
    // system level interrupt
    output logic                   irqOut
);

    // register state
    logic [REG_W-1:0] configReg;
    logic [REG_W-1:0] statusReg;
    logic [REG_W-1:0] irqStatusReg;
    logic [REG_W-1:0] irqMaskReg;
    logic             pullReg;
    logic [DATA_W-1:0] rdataReg;

    // hardware reset synchroniser and filtered level
    logic             hwSync1Reg;
    logic             hwSync2Reg;
    logic             hwSync3Reg;
    logic             hwResetReg;

    // previous event source levels for edge detection
    logic             busyDlyReg;
    logic             ecc2DlyReg;
    logic             ecc1DlyReg;

    // next values and decode
    logic [REG_W-1:0] configNext;
    logic [REG_W-1:0] statusNext;
    logic [REG_W-1:0] irqStatusNext;
    logic [REG_W-1:0] irqMaskNext;
    logic             pullNext;
    logic             hwResetNext;

    wire              busSetup;
    wire              busAccess;
    wire              selConfig;
    wire              selStatus;
    wire              selIrqStatus;
    wire              selIrqMask;
    wire              addrMapped;
    wire              wrEn;
    wire              configWr;
    wire              statusWr;
    wire              irqStatusWr;
    wire              irqMaskWr;
    wire [REG_W-1:0]  wrData;
    wire [REG_W-1:0]  readMux;

    wire              readyEvt;
    wire              ecc2Evt;
    wire              ecc1Evt;
    wire [REG_W-1:0]  evtVec;
    wire [REG_W-1:0]  enabledEvt;
    wire [REG_W-1:0]  cfgRestore;
    wire [REG_W-1:0]  stsRestore;
    wire [REG_W-1:0]  pending;

    // apb phase and address decode
    assign busSetup     = psel & ~penable;
    assign busAccess    = psel & penable;
    assign selConfig    = (paddr == OFF_CONFIG);
    assign selStatus    = (paddr == OFF_STATUS);
    assign selIrqStatus = (paddr == OFF_IRQ_STATUS);
    assign selIrqMask   = (paddr == OFF_IRQ_MASK);
    assign addrMapped   = selConfig | selStatus | selIrqStatus | selIrqMask;
    assign wrEn         = busAccess & pwrite & addrMapped & ~hwResetReg;
    assign configWr     = wrEn & selConfig;
    assign statusWr     = wrEn & selStatus;
    assign irqStatusWr  = wrEn & selIrqStatus;
    assign irqMaskWr    = wrEn & selIrqMask;
    assign wrData       = pwdata[REG_W-1:0];

    // zero wait state slave; unmapped access answers with an error
    assign pready  = 1'b1;
    assign pslverr = busAccess & ~addrMapped;
    assign prdata  = rdataReg;

    // read selection; unmapped reads return zero
    assign readMux = selConfig    ? configReg    :
                     selStatus    ? statusReg    :
                     selIrqStatus ? irqStatusReg :
                     selIrqMask   ? irqMaskReg   : 16'h0000;

    // one-cycle pulses, one per occurrence of each source
    assign readyEvt = busyDlyReg & ~busy;   // busy to ready transition [RULE18]
    assign ecc2Evt  = ecc2Err & ~ecc2DlyReg;  // [RULE18]
    assign ecc1Evt  = ecc1Err & ~ecc1DlyReg;  // [RULE18]
    assign evtVec   = {11'h000, readyEvt, 2'b00, ecc2Evt, ecc1Evt};

    // an event counts only while its channel enable bit is 0
    assign enabledEvt = evtVec & ~configReg & CHAN_MASK;  // [RULE4] [RULE5] [RULE6]

    // writing ones into the config restores flags: bit 15 all channel flags, else per channel
    assign cfgRestore = configWr ?
                        ((wrData[BIT_OUT_DIS] ? CHAN_MASK : 16'h0000)  // [RULE3]
                         | (wrData & CHAN_MASK))                      // [RULE11]
                        : 16'h0000;

    // status writes restore only written ones, power-on flag included
    assign stsRestore = statusWr ? (wrData & (CHAN_MASK | POR_MASK)) : 16'h0000;  // [RULE8]

    // restores then events; an event in the same cycle as its restore wins
    always_comb begin
        statusNext = ((statusReg | cfgRestore | stsRestore) & ~enabledEvt)  // [RULE7] [RULE8]
                     | STS_RSVD_MASK;                                          // [RULE16]
    end

    // config write; reserved bits always read back as 1
    always_comb begin
        configNext = configWr ? (wrData | CFG_RSVD_MASK) : configReg;  // [RULE16]
    end

    // pin pulled while the output is enabled and any enabled flag is low
    assign pending = ~statusReg & ~configReg & CHAN_MASK;  // power-on flag excluded [RULE15]

    always_comb begin
        pullNext = ~configReg[BIT_OUT_DIS] & (|pending);  // [RULE2] [RULE9] [RULE10]
    end

    // system interrupt: sticky, set by raw events, cleared by writing one
    always_comb begin
        irqStatusNext = (irqStatusReg & ~(irqStatusWr ? wrData : 16'h0000)) | evtVec;
        irqMaskNext   = irqMaskWr ? (wrData & CHAN_MASK) : irqMaskReg;
    end

    // a mask bit at 1 blocks its status bit; power-on reset leaves every source unmasked
    assign irqOut = |(irqStatusReg & ~irqMaskReg & CHAN_MASK);

    // open-drain pin: the driven level is always low, only the enable moves
    assign intPinOut = 1'b0;     // [RULE1]
    assign intPinOe  = pullReg;  // [RULE1]

    // hardware reset level counts once the second and third stages agree
    always_comb begin
        hwResetNext = (hwSync2Reg == hwSync3Reg) ? ~hwSync2Reg : hwResetReg;
    end

    // hardware reset pin synchroniser
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            hwSync1Reg <= 1'b1;
            hwSync2Reg <= 1'b1;
            hwSync3Reg <= 1'b1;
            hwResetReg <= 1'b0;
        end else begin
            hwSync1Reg <= hwReset_n;
            hwSync2Reg <= hwSync1Reg;
            hwSync3Reg <= hwSync2Reg;
            hwResetReg <= hwResetNext;
        end
    end

    // event source history
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            busyDlyReg <= 1'b0;
            ecc2DlyReg <= 1'b0;
            ecc1DlyReg <= 1'b0;
        end else begin
            busyDlyReg <= busy;
            ecc2DlyReg <= ecc2Err;
            ecc1DlyReg <= ecc1Err;
        end
    end

    // config, status and registered pin control
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            configReg <= CFG_RESET;      // [RULE12] [RULE16]
            statusReg <= STS_POR_RESET;  // power-on flag cleared [RULE14]
            pullReg   <= 1'b0;           // [RULE12]
        end else if (hwResetReg) begin
            configReg <= CFG_RESET;      // [RULE12]
            statusReg <= STS_HW_RESET;   // [RULE13]
            pullReg   <= 1'b0;           // [RULE12]
        end else begin
            configReg <= configNext;
            statusReg <= statusNext;
            pullReg   <= pullNext;       // [RULE19]
        end
    end

    // system interrupt registers
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            irqStatusReg <= IRQ_RESET;
            irqMaskReg   <= IRQ_RESET;
        end else begin
            irqStatusReg <= irqStatusNext;
            irqMaskReg   <= irqMaskNext;
        end
    end

    // read data captured in the setup phase, held through access
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rdataReg <= 32'h0000_0000;
        end else if (busSetup) begin
            rdataReg <= {16'h0000, readMux};
        end
    end

    // ---------------- assertions ----------------

    default clocking cbSys @(posedge clk_sys);
    endclocking

    default disable iff (!reset_n);

    // no channel activity in a cycle
    sequence s_quiet;
        !readyEvt && !ecc2Evt && !ecc1Evt && !hwResetReg;
    endsequence

    // write of a one into config bit 15
    sequence s_outDisableWrite;
        configWr && wrData[BIT_OUT_DIS] && !readyEvt && !ecc2Evt && !ecc1Evt;
    endsequence

    // enabled 2-bit error arriving with no hardware reset, config write or status write
    sequence s_ecc2Enabled;
        ecc2Evt && !configReg[BIT_ECC2] && !hwResetReg && !configWr && !statusWr;
    endsequence

    // pin condition present: output on and an enabled flag low
    sequence s_pinCause;
        !configReg[BIT_OUT_DIS] && (|pending) && !hwResetReg;
    endsequence

    // the pin is never driven high
    a_pin_drive_low: assert property (intPinOut == 1'b0)  // [RULE1]
        else $error("interrupt pin driven to a high level");

    // disabled output keeps the pin released one edge later
    a_out_gate_off: assert property (configReg[BIT_OUT_DIS] |=> !intPinOe)  // [RULE2]
        else $error("pin pulled while output disabled");

    // bit 15 write restores every channel flag
    a_outdis_restore: assert property (s_outDisableWrite ##0 !hwResetReg |=>  // [RULE3]
                                       ((statusReg & CHAN_MASK) == CHAN_MASK))
        else $error("flags not restored by output disable write");

    // enabled busy-to-ready sets its flag low next edge
    a_ready_flag_set: assert property (  // [RULE4]
        readyEvt && !configReg[BIT_READY] && !hwResetReg |=> !statusReg[BIT_READY])
        else $error("busy-to-ready event not recorded");

    // disabled ready channel leaves its flag alone
    a_ready_flag_off: assert property (configReg[BIT_READY] && statusReg[BIT_READY] |=>  // [RULE4]
                                       statusReg[BIT_READY])
        else $error("disabled ready channel changed its flag");

    // enabled 2-bit error sets its flag and the pin follows one edge later
    a_ecc2_to_pin: assert property (  // [RULE5] [RULE9]
        s_ecc2Enabled ##0 !configReg[BIT_OUT_DIS] |=>
        !statusReg[BIT_ECC2] ##1 (intPinOe || hwResetReg))
        else $error("2-bit error did not reach the pin");

    // enabled 1-bit error sets its flag
    a_ecc1_flag_set: assert property (  // [RULE6]
        ecc1Evt && !configReg[BIT_ECC1] && !hwResetReg |=> !statusReg[BIT_ECC1])
        else $error("1-bit error event not recorded");

    // the 1-bit error flag falls only with its enabled event one edge before
    a_flag_fall_cause: assert property ($fell(statusReg[BIT_ECC1]) |->  // [RULE7] [RULE8]
                                        $past(ecc1Evt && !configReg[BIT_ECC1]))
        else $error("status flag fell without an event");

    // pin follows the cause one edge later and holds while it stays
    a_pin_follows: assert property (s_pinCause |=> intPinOe || hwResetReg)  // [RULE9] [RULE19]
        else $error("pin not pulled for a pending enabled flag");

    // pin released after the last enabled low flag is restored
    a_pin_release: assert property (!(|pending) ##0 s_quiet |=> !intPinOe)  // [RULE10] [RULE15]
        else $error("pin still pulled with no pending flag");

    // writing a channel enable restores its flag
    a_chan_restore: assert property (  // [RULE11]
        configWr && wrData[BIT_READY] && !readyEvt && !hwResetReg |=> statusReg[BIT_READY])
        else $error("channel disable did not restore its flag");

    // hardware reset sets config and status to all ones and releases the pin
    a_hw_reset_vals: assert property (hwResetReg |=> (configReg == CFG_RESET)  // [RULE12] [RULE13]
                                      && (statusReg == STS_HW_RESET) && !intPinOe)
        else $error("hardware reset values wrong");

    // power-on flag rises only through hardware reset or a status write
    a_por_flag_rise: assert property ($rose(statusReg[BIT_POR]) |->  // [RULE14]
                                      $past(hwResetReg || (statusWr && wrData[BIT_POR])))
        else $error("power-on flag rose without cause");

    // reserved bits always read as one
    a_reserved_ones: assert property (((configReg & CFG_RSVD_MASK) == CFG_RSVD_MASK)  // [RULE16]
                                      && ((statusReg & STS_RSVD_MASK) == STS_RSVD_MASK))
        else $error("reserved bit read as zero");

    // a held error level counts only once
    a_single_count: assert property (ecc2Err && $past(ecc2Err) |-> !ecc2Evt)  // [RULE18]
        else $error("held error counted twice");

    // an unmapped access answers with an error in the same cycle
    a_bus_unmapped: assert property (busAccess && !addrMapped |-> pslverr && pready)
        else $error("unmapped access without error");

endmodule

// >>> inc/fei_pkg.sv
// Purpose: constants shared by the flash event interrupt unit
// Assumes: 32-bit APB, one aligned word per register
// Notes:   16-bit register values sit in the low half of each word
//
// Functional notes
// [RULE1] Interrupt pin is open-drain, active low: only pulled low, else released.
// [RULE2] Config bit 15 at 0 enables the pin output; at 1 it stays released.
// [RULE3] Writing 1 into config bit 15 restores every event flag to not-occurred.
// [RULE4] Config bit 4 at 0 makes busy-to-ready an event; at 1 it is ignored.
// [RULE5] Config bit 1 at 0 makes 2-bit ECC detection an event; 1 ignores it.
// [RULE6] Config bit 0 at 0 makes 1-bit ECC detection an event; 1 ignores it.
// [RULE7] Status keeps enabled events as active-low flags at bits 4, 1, 0.
// [RULE8] Status writes only move bits 0 to 1; only events move 1 to 0.
// [RULE9] Enabled output plus enabled event pulls the pin from high to low.
// [RULE10] Pin released only when every low, enabled flag is restored to 1.
// [RULE11] Writing 1 to a channel enable disables it and restores its flag.
// [RULE12] Both resets set all config bits to 1 and release the pin.
// [RULE13] Hardware reset sets every status bit to 1, power-on flag included.
// [RULE14] Power-on reset clears status bit 2; restored by hardware reset or write.
// [RULE15] Power-on detect flag never influences the interrupt pin.
// [RULE16] Reserved config and status bits hold 1 after both reset types.
// [RULE17] Host reads status after seeing the pin low, before clearing flags.
// [RULE18] Each event source counts once per occurrence, as a one-cycle pulse.
// [RULE19] Pin pull-down is registered, changing the edge after a register update.
package fei_pkg;

    // bus geometry
    localparam int          ADDR_W         = 8;
    localparam int          DATA_W         = 32;
    localparam int          REG_W          = 16;

    // register byte offsets
    localparam logic [7:0]  OFF_CONFIG     = 8'h00;
    localparam logic [7:0]  OFF_STATUS     = 8'h04;
    localparam logic [7:0]  OFF_IRQ_STATUS = 8'h08;
    localparam logic [7:0]  OFF_IRQ_MASK   = 8'h0C;

    // field positions in config and status; only the channel bits are in both
    localparam int          BIT_OUT_DIS    = 15;
    localparam int          BIT_READY      = 4;
    localparam int          BIT_POR        = 2;
    localparam int          BIT_ECC2       = 1;
    localparam int          BIT_ECC1       = 0;

    // field masks
    localparam logic [15:0] CHAN_MASK      = 16'h0013;
    localparam logic [15:0] POR_MASK       = 16'h0004;
    localparam logic [15:0] CFG_RSVD_MASK  = 16'h7FEC;
    localparam logic [15:0] STS_RSVD_MASK  = 16'hFFE8;

    // reset values
    localparam logic [15:0] CFG_RESET      = 16'hFFFF;
    localparam logic [15:0] STS_POR_RESET  = 16'hFFFB;
    localparam logic [15:0] STS_HW_RESET   = 16'hFFFF;
    localparam logic [15:0] IRQ_RESET      = 16'h0000;

endpackage

// >>> tb/fei_host_pin_model.sv
// Purpose: host side of the open-drain interrupt wire, with its pull-up
// Assumes: the device drives intPinOut only while intPinOe is high
// Notes:   pinLevel is the wire level the host controller samples
`timescale 1ns/1ps

module fei_host_pin_model (
    // device side of the pin
    input  wire logic intPinOut,
    input  wire logic intPinOe,
    // wire level seen by the host
    output logic      pinLevel
);
    // pull-up holds the wire high whenever the device lets go
    assign pinLevel = (intPinOe === 1'b1) ? intPinOut : 1'b1;
endmodule

// >>> tb/flash_event_interrupt_unit_tb.sv
// Purpose: self-checking bench for the flash event interrupt unit
// Assumes: zero-wait apb slave, pin level resolved by the host model
// Notes:   each test is a sequence of register calls and pin checks
`timescale 1ns/1ps

module flash_event_interrupt_unit_tb
    import fei_pkg::*;
;
    logic              clk_sys = 1'b0;
    logic              reset_n = 1'b0;
    logic              hwReset_n = 1'b1;
    logic              busy = 1'b0;
    logic              ecc2Err = 1'b0;
    logic              ecc1Err = 1'b0;
    logic              psel = 1'b0;
    logic              penable = 1'b0;
    logic              pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = 8'h00;
    logic [DATA_W-1:0] pwdata = 32'h0000_0000;
    logic [DATA_W-1:0] prdata;
    logic              pready;
    logic              pslverr;
    logic              intPinOut;
    logic              intPinOe;
    logic              irqOut;
    logic              pinLevel;
    int                err_count = 0;
    int                check_count = 0;
    int                chs[3] = '{BIT_ECC1, BIT_ECC2, BIT_READY};

    // clock at 200 MHz
    always #2.5 clk_sys = ~clk_sys;

    fei_flash_event_irq i_dut (
        .clk_sys(clk_sys), .reset_n(reset_n), .hwReset_n(hwReset_n), .busy(busy),
        .ecc2Err(ecc2Err), .ecc1Err(ecc1Err), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .intPinOut(intPinOut),
        .intPinOe(intPinOe), .irqOut(irqOut)
    );

    fei_host_pin_model i_host (.intPinOut(intPinOut), .intPinOe(intPinOe), .pinLevel(pinLevel));

    // compare and count
    task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", n, exp, seen);
        end
    endtask

    // one apb transfer, held until pready at a rising edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rdat, output logic er);
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        while (pready !== 1'b1) begin
            @(posedge clk_sys);
        end
        rdat = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        logic [31:0] x;
        logic        e;
        apb(1'b1, a, {16'h0000, d}, x, e);
    endtask

    task automatic rd(input logic [7:0] a, input logic [15:0] ex, input string n);
        logic [31:0] x;
        logic        e;
        apb(1'b0, a, 32'h0000_0000, x, e);
        chk(n, x, {16'h0000, ex});
        chk("pslverr", {31'h0000_0000, e}, 32'h0000_0000);
    endtask

    // let the registered pin settle, then look at the wire level
    task automatic pin(input logic ex);
        repeat (3) @(posedge clk_sys);
        chk("pinLevel", {31'h0000_0000, pinLevel}, {31'h0000_0000, ex});
    endtask

    task automatic irq(input logic ex);
        @(negedge clk_sys);
        chk("irqOut", {31'h0000_0000, irqOut}, {31'h0000_0000, ex});
    endtask

    // one event on channel c, source active for len cycles
    task automatic ev(input int c, input int len);
        @(posedge clk_sys);
        if (c == BIT_READY) busy <= 1'b1;
        else if (c == BIT_ECC2) ecc2Err <= 1'b1;
        else ecc1Err <= 1'b1;
        repeat (len) @(posedge clk_sys);
        busy <= 1'b0;
        ecc2Err <= 1'b0;
        ecc1Err <= 1'b0;
        repeat (6) @(posedge clk_sys);
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    // watchdog well beyond the few hundred cycles the tests need
    initial begin
        #100000;
        err_count++;
        stop_test();
    end

    initial begin
        logic [31:0] x;
        logic        e;
        logic [15:0] b;
        repeat (3) @(posedge clk_sys);
        reset_n <= 1'b1;
        // power-on values and the power-on flag that never drives the pin
        rd(OFF_CONFIG, 16'hFFFF, "config");
        rd(OFF_STATUS, 16'hFFFB, "status");
        wr(OFF_CONFIG, 16'h7FFF);
        pin(1'b1);
        wr(OFF_STATUS, 16'h0004);
        rd(OFF_STATUS, 16'hFFFF, "status");
        $display("test reset values done");
        // each channel: enabled event, host read, disable, masked event
        foreach (chs[i]) begin
            b = 16'h0001 << chs[i];
            wr(OFF_CONFIG, 16'h7FFF & ~b);
            ev(chs[i], 1);
            pin(1'b0);
            rd(OFF_STATUS, 16'hFFFF & ~b, "status");
            wr(OFF_CONFIG, 16'h7FFF);
            rd(OFF_STATUS, 16'hFFFF, "status");
            pin(1'b1);
            ev(chs[i], 1);
            rd(OFF_STATUS, 16'hFFFF, "status");
            pin(1'b1);
            rd(OFF_IRQ_STATUS, b, "irqStatus");
            irq(1'b1);
            wr(OFF_IRQ_MASK, b);
            irq(1'b0);
            wr(OFF_IRQ_STATUS, b);
            wr(OFF_IRQ_MASK, 16'h0000);
            rd(OFF_IRQ_STATUS, 16'h0000, "irqStatus");
            irq(1'b0);
        end
        $display("test channels done");
        // two flags low, partial restore, held source, output gate
        wr(OFF_CONFIG, 16'h7FFC);
        ev(BIT_ECC2, 1);
        ecc1Err <= 1'b1;
        repeat (6) @(posedge clk_sys);
        rd(OFF_STATUS, 16'hFFFC, "status");
        wr(OFF_STATUS, 16'h0001);
        rd(OFF_STATUS, 16'hFFFD, "status");
        pin(1'b0);
        ecc1Err <= 1'b0;
        wr(OFF_STATUS, 16'h0000);
        rd(OFF_STATUS, 16'hFFFD, "status");
        wr(OFF_CONFIG, 16'hFFFC);
        rd(OFF_STATUS, 16'hFFFF, "status");
        pin(1'b1);
        ev(BIT_ECC1, 1);
        rd(OFF_STATUS, 16'hFFFE, "status");
        pin(1'b1);
        wr(OFF_CONFIG, 16'h7FFC);
        pin(1'b0);
        wr(OFF_STATUS, 16'h0001);
        pin(1'b1);
        wr(OFF_IRQ_STATUS, 16'h0013);
        $display("test flags done");
        // unmapped address refused
        apb(1'b0, 8'h10, 32'h0000_0000, x, e);
        chk("pslverr", {31'h0000_0000, e}, 32'h0000_0001);
        chk("prdata", x, 32'h0000_0000);
        $display("test unmapped done");
        // power-on reset in mid-run with the pin low
        wr(OFF_CONFIG, 16'h7FFE);
        ev(BIT_ECC1, 1);
        pin(1'b0);
        @(posedge clk_sys);
        reset_n <= 1'b0;
        pin(1'b1);
        reset_n <= 1'b1;
        rd(OFF_CONFIG, 16'hFFFF, "config");
        rd(OFF_STATUS, 16'hFFFB, "status");
        // hardware reset with the pin low
        wr(OFF_CONFIG, 16'h7FFE);
        ev(BIT_ECC1, 1);
        pin(1'b0);
        hwReset_n <= 1'b0;
        repeat (6) @(posedge clk_sys);
        pin(1'b1);
        hwReset_n <= 1'b1;
        repeat (8) @(posedge clk_sys);
        rd(OFF_CONFIG, 16'hFFFF, "config");
        rd(OFF_STATUS, 16'hFFFF, "status");
        $display("test resets done");
        stop_test();
    end
endmodule
